/* phystr_top.sv */
// Contract
// - A high power-down pin puts the device in power-down, only management stays alive.
// - In power-down management still answers and the MII outputs make no transitions.
// - Power-down ends only on a hardware or software reset taken with the pin low.
// - The status pin shows cable presence when strapped low and link when strapped high.
// - The three mode straps pick the operating mode from the eight-entry mode table.
// - The mode straps are sampled at power-up or reset and held as configuration.
// - The interface strap picks normal MII when low and reduced MII when high.
// - Reduced MII runs from a 50 MHz reference on the crystal output, others from 25 MHz.
// - Reduced MII moves two data bits a clock, seven-wire mode one serial bit a clock.
// - After a hardware or software reset the LEDs flash once for 500 ms.
// - An LED strapped high is driven active low, one strapped low active high.
// - In every transmit clock with enable high the device takes the data nibble; the code: normal MII each clock, reduced MII every 2nd, seven-wire every 4th.
// - The device sources the transmit clock that times enable, data and error; with reduced MII the code holds mii_tx_clk low.
`default_nettype none
module phystr_top
  import phystr_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = LED_FLASH_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sw_reset,
  input wire logic power_down_pin,
  input wire logic rmii_strap_pin,
  input wire logic seven_wire_serial_mode,
  input wire logic [2:0] led_pin_in,
  output logic [2:0] led_pin_out,
  output logic [2:0] led_pin_oe,
  input wire logic status_pin_in,
  output logic status_pin_out,
  output logic status_pin_oe,
  input wire logic cable_attached,
  input wire logic link_good,
  input wire logic speed_is_100,
  input wire logic duplex_is_full,
  input wire logic activity,
  output logic power_down,
  output logic core_enable,
  output logic straps_valid,
  output logic [2:0] cfg_mode,
  output logic cfg_auto_neg,
  output logic cfg_dual_speed,
  output logic cfg_speed_100,
  output logic cfg_full_duplex,
  output logic cfg_reserved,
  output logic cfg_rmii,
  output logic cfg_seven_wire,
  output logic refclk_sel_50m,
  output logic tx_busy,
  input wire logic tx_clk,
  output logic mii_tx_clk,
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic mii_tx_er,
  output logic [3:0] tx_nibble,
  output logic tx_nibble_valid,
  output logic tx_nibble_err,
  output logic tx_frame
);

  if (FLASH_CYCLES < 1) begin : g_bad_flash
    $error("phystr_top: FLASH_CYCLES must be at least 1");
  end

  // ============================================================
  // Pin synchronisers
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic pd_pin;

  assign pins_raw = {led_pin_in, status_pin_in, seven_wire_serial_mode,
                     rmii_strap_pin, power_down_pin};
  assign pd_pin = pins_s[PIN_PD];

  phystr_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // ============================================================
  // Control state
  phystr_state_type state_ff;
  phystr_state_type nxt_state;
  logic [STRAP_CNT_W-1:0] settle_ff;
  logic [STRAP_CNT_W-1:0] nxt_settle;
  logic strap_take;
  logic sw_wake;
  logic flash_busy;

  // Pins are released while sampling, so straps settle through both sync stages
  assign strap_take = (state_ff == ST_SAMPLE) && (settle_ff == STRAP_LAST);
  // A software reset with the pin still high leaves the device asleep
  assign sw_wake = sw_reset && ((state_ff != ST_DOWN) || !pd_pin);
  assign nxt_settle = (state_ff == ST_SAMPLE && !sw_reset) ? settle_ff + 1'b1 : '0;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_SAMPLE: begin
        if (strap_take) begin
          nxt_state = pd_pin ? ST_DOWN : ST_FLASH;
        end
      end
      ST_FLASH: begin
        if (pd_pin) begin
          nxt_state = ST_DOWN;
        end else if (!flash_busy) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pd_pin) begin
          nxt_state = ST_DOWN;
        end
      end
      ST_DOWN: begin
        nxt_state = ST_DOWN;
      end
    endcase
    if (sw_wake) begin
      nxt_state = ST_SAMPLE;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_SAMPLE;
      settle_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      settle_ff <= nxt_settle;
    end
  end

  phystr_flash_timer #(
    .CYCLES(FLASH_CYCLES)
  ) u_flash (
    .clock(clock),
    .rst_n(rst_n),
    .start(strap_take),
    .busy(flash_busy)
  );

  // ============================================================
  // Latched straps
  logic [2:0] mode_ff;
  logic status_sel_ff;
  logic rmii_ff;
  logic seven_strap_ff;
  logic [2:0] led_pol_ff;
  logic valid_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_RESET;
      status_sel_ff <= STATUS_SEL_RESET;
      rmii_ff <= RMII_RESET;
      seven_strap_ff <= SEVEN_STRAP_RESET;
      led_pol_ff <= LED_POL_RESET;
      valid_ff <= 1'b0;
    end else if (strap_take) begin
      // Mode bits share the LED pins: bit0 duplex, bit1 speed, bit2 link
      mode_ff <= pins_s[PIN_LED +: 3];
      status_sel_ff <= pins_s[PIN_STATUS];
      rmii_ff <= pins_s[PIN_RMII];
      seven_strap_ff <= pins_s[PIN_SEVEN];
      led_pol_ff <= pins_s[PIN_LED +: 3];
      valid_ff <= 1'b1;
    end else if (sw_wake) begin
      valid_ff <= 1'b0;
    end
  end

  // ============================================================
  // Mode decode
  logic dec_auto;
  logic dec_dual;
  logic dec_100;
  logic dec_full;
  logic dec_rsvd;
  logic dec_10_forced;
  logic dec_seven;

  assign dec_auto = (mode_ff == MODE_AUTO_ALL);
  assign dec_dual = (mode_ff == MODE_DUAL_HALF) || dec_auto;
  assign dec_100 = (mode_ff == MODE_100_HALF) || (mode_ff == MODE_100_FULL);
  assign dec_full = (mode_ff == MODE_10_FULL) || (mode_ff == MODE_100_FULL)
                    || dec_auto;
  assign dec_rsvd = (mode_ff == MODE_RSVD_1) || (mode_ff == MODE_RSVD_2);
  assign dec_10_forced = (mode_ff == MODE_10_HALF) || (mode_ff == MODE_10_FULL);
  // Serial mode exists only for forced 10M and never beside reduced MII
  assign dec_seven = !seven_strap_ff && dec_10_forced && !rmii_ff;

  logic [9:0] cfg_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '0;
    end else begin
      cfg_ff <= {mode_ff, dec_auto, dec_dual, dec_100, dec_full, dec_rsvd,
                 rmii_ff, dec_seven};
    end
  end

  assign cfg_mode = cfg_ff[9:7];
  assign cfg_auto_neg = cfg_ff[6];
  assign cfg_dual_speed = cfg_ff[5];
  assign cfg_speed_100 = cfg_ff[4];
  assign cfg_full_duplex = cfg_ff[3];
  assign cfg_reserved = cfg_ff[2];
  assign cfg_rmii = cfg_ff[1];
  assign cfg_seven_wire = cfg_ff[0];
  assign refclk_sel_50m = cfg_ff[1];
  assign straps_valid = valid_ff;

  // ============================================================
  // Activity blanking of the link LED
  logic act_any;
  logic [ACT_CNT_W-1:0] act_cnt_ff;
  logic [ACT_CNT_W-1:0] nxt_act_cnt;

  assign act_any = activity || tx_busy;
  assign nxt_act_cnt = (act_any && act_cnt_ff == '0) ? ACT_CNT_W'(ACT_OFF_CYCLES - 1)
                       : (act_cnt_ff != '0) ? act_cnt_ff - 1'b1 : '0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_cnt_ff <= '0;
    end else begin
      act_cnt_ff <= nxt_act_cnt;
    end
  end

  // ============================================================
  // LED and status pins
  logic [2:0] led_on;
  logic [2:0] nxt_led_out;
  logic nxt_oe;
  logic nxt_status;
  logic [2:0] led_out_ff;
  logic [2:0] led_oe_ff;
  logic status_out_ff;
  logic status_oe_ff;

  always_comb begin
    led_on = '0;
    unique case (state_ff)
      ST_FLASH: begin
        led_on = 3'h7;
      end
      ST_RUN: begin
        led_on[LED_DUPLEX] = duplex_is_full;
        led_on[LED_SPEED] = speed_is_100;
        led_on[LED_LINK] = link_good && (act_cnt_ff == '0);
      end
      ST_SAMPLE, ST_DOWN: begin
        led_on = '0;
      end
    endcase
  end

  // Strapped high means the LED sinks, so its on level is low
  assign nxt_led_out = led_on ^ led_pol_ff;
  assign nxt_oe = (state_ff != ST_SAMPLE);
  assign nxt_status = (state_ff == ST_RUN || state_ff == ST_FLASH)
                      && (status_sel_ff ? link_good : cable_attached);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      led_out_ff <= '0;
      led_oe_ff <= '0;
      status_out_ff <= 1'b0;
      status_oe_ff <= 1'b0;
    end else begin
      led_out_ff <= nxt_led_out;
      led_oe_ff <= {3{nxt_oe}};
      status_out_ff <= nxt_status;
      status_oe_ff <= nxt_oe;
    end
  end

  assign led_pin_out = led_out_ff;
  assign led_pin_oe = led_oe_ff;
  assign status_pin_out = status_out_ff;
  assign status_pin_oe = status_oe_ff;
  assign power_down = (state_ff == ST_DOWN);
  assign core_enable = (state_ff == ST_FLASH) || (state_ff == ST_RUN);

  // ============================================================
  // Link domain reset and crossings
  logic lrst_meta_ff;
  logic lrst_n_ff;

  always_ff @(posedge tx_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_meta_ff <= 1'b0;
      lrst_n_ff <= 1'b0;
    end else begin
      lrst_meta_ff <= 1'b1;
      lrst_n_ff <= lrst_meta_ff;
    end
  end

  // Mode bits change one clock after the run level rises, since cfg_ff is registered from the latched straps
  logic [2:0] lk_s;
  logic lk_run;
  logic lk_rmii;
  logic lk_7w;
  logic tx_frame_ff;

  phystr_sync #(
    .WIDTH(3)
  ) u_to_link (
    .clock(tx_clk),
    .rst_n(lrst_n_ff),
    .async_in({cfg_ff[0], cfg_ff[1], core_enable}),
    .sync_out(lk_s)
  );

  assign lk_run = lk_s[0];
  assign lk_rmii = lk_s[1];
  assign lk_7w = lk_s[2];

  phystr_sync #(
    .WIDTH(1)
  ) u_to_core (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(tx_frame_ff),
    .sync_out(tx_busy)
  );

  // ============================================================
  // Transmit clock output
  logic gate_ff;

  // Falling-edge enable keeps the gated clock free of runt pulses
  always_ff @(negedge tx_clk or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      gate_ff <= 1'b0;
    end else begin
      gate_ff <= lk_run && !lk_rmii;
    end
  end

  assign mii_tx_clk = tx_clk && gate_ff;

  // ============================================================
  // Transmit nibble capture
  logic [1:0] beat_ff;
  logic [3:0] sh_ff;
  logic [3:0] nxt_sh;
  logic [1:0] beat_last;
  logic lk_take;
  logic lk_done;
  logic [3:0] tx_nibble_ff;
  logic tx_valid_ff;
  logic tx_err_ff;

  // Enable low is taken as frame end; a partial nibble is dropped
  assign lk_take = lk_run && mii_tx_en;
  assign beat_last = lk_7w ? 2'h3 : (lk_rmii ? 2'h1 : 2'h0);
  assign nxt_sh = lk_7w ? {mii_txd[0], sh_ff[3:1]}
                  : (lk_rmii ? {mii_txd[1:0], sh_ff[3:2]} : mii_txd);
  assign lk_done = lk_take && (beat_ff == beat_last);

  always_ff @(posedge tx_clk or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      beat_ff <= '0;
      sh_ff <= '0;
      tx_nibble_ff <= '0;
      tx_valid_ff <= 1'b0;
      tx_err_ff <= 1'b0;
      tx_frame_ff <= 1'b0;
    end else begin
      beat_ff <= (lk_take && !lk_done) ? beat_ff + 1'b1 : '0;
      sh_ff <= lk_take ? nxt_sh : '0;
      tx_nibble_ff <= lk_done ? nxt_sh : tx_nibble_ff;
      tx_valid_ff <= lk_done;
      tx_err_ff <= lk_done && mii_tx_er && !lk_rmii && !lk_7w;
      tx_frame_ff <= lk_take;
    end
  end

  assign tx_nibble = tx_nibble_ff;
  assign tx_nibble_valid = tx_valid_ff;
  assign tx_nibble_err = tx_err_ff;
  assign tx_frame = tx_frame_ff;

endmodule
`default_nettype wire

/* phystr_pkg.sv */
`default_nettype none
package phystr_pkg;

  // ============================================================
  // Clocking and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned LED_FLASH_MS = 500;
  localparam int unsigned LED_FLASH_CYCLES = LED_FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned REFCLK_RMII_MHZ = 50;
  localparam int unsigned REFCLK_MII_MHZ = 25;
  localparam int unsigned STRAP_SETTLE_CYCLES = 4;
  localparam int unsigned STRAP_CNT_W = 3;
  localparam logic [STRAP_CNT_W-1:0] STRAP_LAST = STRAP_CNT_W'(STRAP_SETTLE_CYCLES - 1);
  localparam int unsigned ACT_OFF_CYCLES = 2048;
  localparam int unsigned ACT_CNT_W = 12;

  // ============================================================
  // Strap and pin bundle positions
  localparam int unsigned PIN_PD = 0;
  localparam int unsigned PIN_RMII = 1;
  localparam int unsigned PIN_SEVEN = 2;
  localparam int unsigned PIN_STATUS = 3;
  localparam int unsigned PIN_LED = 4;
  localparam int unsigned PIN_W = 7;
  localparam int unsigned LED_DUPLEX = 0;
  localparam int unsigned LED_SPEED = 1;
  localparam int unsigned LED_LINK = 2;
  localparam int unsigned NIB_W = 4;

  // ============================================================
  // Reset values of latched straps
  localparam logic [2:0] MODE_RESET = 3'h7;
  localparam logic STATUS_SEL_RESET = 1'b0;
  localparam logic RMII_RESET = 1'b0;
  localparam logic SEVEN_STRAP_RESET = 1'b1;
  localparam logic [2:0] LED_POL_RESET = 3'h7;

  // ============================================================
  // Operating modes and control states
  typedef enum logic [2:0] {
    MODE_DUAL_HALF = 3'h0,
    MODE_RSVD_1 = 3'h1,
    MODE_RSVD_2 = 3'h2,
    MODE_10_HALF = 3'h3,
    MODE_10_FULL = 3'h4,
    MODE_100_HALF = 3'h5,
    MODE_100_FULL = 3'h6,
    MODE_AUTO_ALL = 3'h7
  } phystr_mode_type;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'h0,
    ST_FLASH = 2'h1,
    ST_RUN = 2'h2,
    ST_DOWN = 2'h3
  } phystr_state_type;

endpackage
`default_nettype wire

/* phystr_sync.sv */
`default_nettype none
module phystr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH == 0) begin : g_bad_width
    $error("phystr_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      hold_ff <= '0;
    end else begin
      meta_ff <= async_in;
      hold_ff <= meta_ff;
    end
  end

  assign sync_out = hold_ff;

endmodule
`default_nettype wire

/* phystr_flash_timer.sv */
`default_nettype none
module phystr_flash_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("phystr_flash_timer: CYCLES must be at least 1");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  assign busy = (cnt_ff != '0);
  assign nxt_cnt = start ? CNT_W'(CYCLES) : (busy ? cnt_ff - 1'b1 : cnt_ff);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule
`default_nettype wire

/* phystr_props.sv */
`default_nettype none
// ====================
// Checker on top ports
module phystr_props
  import phystr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tx_clk,
  input wire logic sw_reset,
  input wire logic power_down_pin,
  input wire logic rmii_strap_pin,
  input wire logic [2:0] led_pin_in,
  input wire logic [2:0] led_pin_out,
  input wire logic [2:0] led_pin_oe,
  input wire logic status_pin_out,
  input wire logic power_down,
  input wire logic core_enable,
  input wire logic straps_valid,
  input wire logic [2:0] cfg_mode,
  input wire logic cfg_auto_neg,
  input wire logic cfg_dual_speed,
  input wire logic cfg_full_duplex,
  input wire logic cfg_reserved,
  input wire logic cfg_rmii,
  input wire logic cfg_seven_wire,
  input wire logic refclk_sel_50m,
  input wire logic mii_tx_clk,
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_nibble_valid,
  input wire logic tx_frame
);
  sequence s_flash_on;
    (led_pin_oe == 3'h7 && led_pin_out == ~led_pin_in) [*8];
  endsequence
  sequence s_long_down;
    power_down [*8];
  endsequence
  property p_pd_entry;
    @(posedge clock) disable iff (!rst_n) (straps_valid && power_down_pin) [*5] |-> power_down;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("no power-down");
  property p_pd_hold;
    @(posedge clock) disable iff (!rst_n) power_down && !sw_reset |=> power_down;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("left power-down");
  property p_pd_quiet;
    @(posedge clock) disable iff (!rst_n) power_down && $past(power_down)
      |-> !status_pin_out && led_pin_out == led_pin_in;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("pins active in power-down");
  // Allows the link-side gate a few cycles to catch up
  property p_pd_txclk;
    @(posedge clock) disable iff (!rst_n) s_long_down |-> !mii_tx_clk;
  endproperty
  a_pd_txclk: assert property (p_pd_txclk) else $error("tx clock runs");
  property p_cfg;
    @(posedge clock) disable iff (!rst_n) straps_valid && $past(straps_valid)
      |-> cfg_auto_neg == (cfg_mode == 3'h7) && cfg_reserved == (cfg_mode inside {3'h1, 3'h2})
      && cfg_full_duplex == (cfg_mode inside {3'h4, 3'h6, 3'h7})
      && cfg_dual_speed == (cfg_mode inside {3'h0, 3'h7});
  endproperty
  a_cfg: assert property (p_cfg) else $error("mode decode wrong");
  property p_refclk;
    @(posedge clock) disable iff (!rst_n) $rose(straps_valid)
      |=> refclk_sel_50m == $past(rmii_strap_pin, 4) && refclk_sel_50m == cfg_rmii;
  endproperty
  a_refclk: assert property (p_refclk) else $error("reference select wrong");
  property p_flash;
    @(posedge clock) disable iff (!rst_n) $rose(core_enable) |=> s_flash_on;
  endproperty
  a_flash: assert property (p_flash) else $error("no flash after reset");
  property p_tx_take;
    @(posedge tx_clk) disable iff (!rst_n) mii_tx_en && !cfg_rmii && !cfg_seven_wire
      |=> (tx_frame |-> tx_nibble_valid && tx_nibble == $past(mii_txd));
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("nibble not taken");
  property p_tx_stop;
    @(posedge tx_clk) disable iff (!rst_n) !mii_tx_en |=> !tx_frame && !tx_nibble_valid;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("nibble without enable");
endmodule

bind phystr_top phystr_props phystr_props_inst (.clock, .rst_n, .tx_clk, .sw_reset,
  .power_down_pin, .rmii_strap_pin, .led_pin_in, .led_pin_out, .led_pin_oe, .status_pin_out,
  .power_down,
  .core_enable, .straps_valid, .cfg_mode, .cfg_auto_neg, .cfg_dual_speed, .cfg_full_duplex,
  .cfg_reserved, .cfg_rmii, .cfg_seven_wire, .refclk_sel_50m, .mii_tx_clk, .mii_txd,
  .mii_tx_en, .tx_nibble, .tx_nibble_valid, .tx_frame);
`default_nettype wire

/* phystr_mac.sv */
`default_nettype none
// ====================
// MAC transmit side
module phystr_mac (
  input wire logic tx_clk,
  output logic [3:0] mii_txd,
  output logic mii_tx_en,
  output logic mii_tx_er
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] q[$];
  initial begin
    mii_txd = 4'h5;
    mii_tx_en = 1'b0;
    mii_tx_er = 1'b0;
  end
  // Unused lines toggle so stale data can never look valid
  task automatic send(input int beats, input int gap);
    logic [3:0] n;
    repeat (gap + 1) begin
      @(posedge tx_clk);
      #2 mii_txd = ~mii_txd;
    end
    while (q.size() > 0) begin
      n = q.pop_front();
      for (int b = 0; b < beats; b++) begin
        @(posedge tx_clk);
        #2 mii_tx_en = 1'b1;
        mii_txd = (beats == 4) ? {~mii_txd[3:1], n[b]} :
          (beats == 2) ? {~mii_txd[3:2], n[2*b+:2]} : n;
      end
    end
    @(posedge tx_clk);
    #2 mii_tx_en = 1'b0;
    mii_txd = ~mii_txd;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
`default_nettype none
// ====================
// Bench
module tb
  import phystr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FC = 20;
  logic clock = 1'b0, tx_clk = 1'b0, rst_n = 1'b0, sw_reset = 1'b0, power_down_pin = 1'b0;
  logic rmii_strap_pin = 1'b0, seven_wire_serial_mode = 1'b1, status_pin_in = 1'b0;
  logic cable_attached = 1'b0, link_good = 1'b0, speed_is_100 = 1'b0;
  logic duplex_is_full = 1'b0, activity = 1'b0;
  logic [2:0] led_pin_in = 3'h7, led_pin_out, led_pin_oe, cfg_mode;
  logic status_pin_out, status_pin_oe, power_down, core_enable, straps_valid, cfg_auto_neg;
  logic cfg_dual_speed, cfg_speed_100, cfg_full_duplex, cfg_reserved, cfg_rmii, cfg_seven_wire;
  logic refclk_sel_50m, tx_busy, mii_tx_clk, mii_tx_en, mii_tx_er, tx_nibble_valid, tx_frame;
  logic [3:0] mii_txd, tx_nibble, got_q[$];
  logic [7:0] seed = 8'h27;
  int error_cnt = 0, tests_run = 0;
  wire logic [7:0] cfg_bits = {cfg_speed_100, cfg_auto_neg, cfg_full_duplex, cfg_reserved, cfg_rmii,
    refclk_sel_50m, cfg_seven_wire, cfg_dual_speed};

  phystr_top #(.FLASH_CYCLES(FC)) phystr_top_inst (.clock, .rst_n, .sw_reset,
    .power_down_pin, .rmii_strap_pin, .seven_wire_serial_mode, .led_pin_in, .led_pin_out,
    .led_pin_oe, .status_pin_in, .status_pin_out, .status_pin_oe, .cable_attached, .link_good,
    .speed_is_100, .duplex_is_full, .activity, .power_down, .core_enable, .straps_valid,
    .cfg_mode, .cfg_auto_neg, .cfg_dual_speed, .cfg_speed_100, .cfg_full_duplex, .cfg_reserved,
    .cfg_rmii, .cfg_seven_wire, .refclk_sel_50m, .tx_busy, .tx_clk, .mii_tx_clk, .mii_txd,
    .mii_tx_en, .mii_tx_er, .tx_nibble, .tx_nibble_valid, .tx_nibble_err(), .tx_frame);
  phystr_mac phystr_mac_inst (.tx_clk, .mii_txd, .mii_tx_en, .mii_tx_er);

  initial forever #25 clock = ~clock;
  initial begin
    #7;
    forever #24 tx_clk = ~tx_clk;
  end
  always @(posedge tx_clk) if (tx_nibble_valid === 1'b1) got_q.push_back(tx_nibble);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Serial strap follows the reduced strap, so forced 10M without it is seven-wire
  function automatic logic [7:0] exp_cfg(input logic [2:0] m, input logic r);
    return {m inside {3'h5, 3'h6}, m == 3'h7, m inside {3'h4, 3'h6, 3'h7}, m inside {3'h1, 3'h2},
      r, r, !r && m inside {3'h3, 3'h4}, m inside {3'h0, 3'h7}};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic wait_valid;
    int k = 0;
    while (straps_valid !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    tick(2);
    chk(straps_valid, 1'b1);
  endtask
  task automatic frame(input int beats, input bit live);
    logic [3:0] exp_q[$];
    seed = lfsr(seed);
    got_q = {};
    repeat (4 + seed[2:0]) begin
      seed = lfsr(seed);
      exp_q.push_back(seed[3:0]);
      phystr_mac_inst.q.push_back(seed[3:0]);
    end
    phystr_mac_inst.send(beats, int'(seed[5:4]));
    repeat (4) @(posedge tx_clk);
    if (!live) exp_q = {};
    chk(8'(got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) chk(got_q[i], exp_q[i]);
    tick(1);
  endtask
  task automatic boot(input logic [2:0] m, input logic r, input logic st);
    logic [7:0] x;
    x = exp_cfg(m, r);
    rst_n = 1'b0;
    led_pin_in = m;
    rmii_strap_pin = r;
    seven_wire_serial_mode = r;
    status_pin_in = st;
    tick(4);
    rst_n = 1'b1;
    wait_valid();
    chk(cfg_mode, m);
    chk(cfg_bits, x);
    chk(led_pin_out, {~m});
    chk({status_pin_oe, led_pin_oe}, 8'h0f);
    tick(FC + 2);
    seed = lfsr(seed);
    {link_good, cable_attached, speed_is_100, duplex_is_full} = seed[3:0];
    tick(3);
    chk(led_pin_out, {link_good, speed_is_100, duplex_is_full} ^ m);
    chk(status_pin_out, st ? link_good : cable_attached);
    frame(r ? 2 : (x[1] ? 4 : 1), 1'b1);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      boot(3'(i), i[3], seed[6]);
    end
    // Normal MII last, so the gated transmit clock is live before power-down
    boot(3'h7, 1'b0, 1'b1);
    link_good = 1'b1;
    activity = 1'b1;
    tick(1);
    activity = 1'b0;
    tick(3);
    chk(led_pin_out[2], 1'b1);
    power_down_pin = 1'b1;
    tick(6);
    chk({power_down, core_enable}, 2'b10);
    frame(1, 1'b0);
    sw_reset = 1'b1;
    tick(1);
    sw_reset = 1'b0;
    tick(4);
    chk(power_down, 1'b1);
    power_down_pin = 1'b0;
    tick(6);
    chk(power_down, 1'b1);
    sw_reset = 1'b1;
    tick(1);
    sw_reset = 1'b0;
    wait_valid();
    tick(FC + 4);
    chk({power_down, core_enable}, 2'b01);
    frame(1, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
